// ==== design/sisl_map.svh ====
// register offsets, reset values and field positions of the stage interrupt block
`ifndef SISL_MAP_SVH
`define SISL_MAP_SVH

`define SISL_ADDR_W          10
`define SISL_ADDR_UNDER_EN   10'h005
`define SISL_ADDR_OVER_EN    10'h006
`define SISL_ADDR_DONE_EN    10'h007
`define SISL_ADDR_UNDER_STS  10'h008
`define SISL_ADDR_OVER_STS   10'h009
`define SISL_ADDR_DONE_STS   10'h00a
`define SISL_EN_RESET        8'h00
`define SISL_STS_RESET       8'h00
`define SISL_WORD_RESET      16'h0000
`define SISL_STAGE_LSB       0
`define SISL_STAGE_MSB       7
`define SISL_TEST_BIT        12
`define SISL_NO_HOLD         8'h00
`define SISL_TEST_RESET      1'b0
`define SISL_IRQ_IDLE        1'b1

`endif

// ==== design/sisl_pkg.sv ====
// types shared by the stage interrupt block
`default_nettype none
package sisl_pkg;
    typedef logic [7:0]  sisl_stage_vec_t;
    typedef logic [15:0] sisl_word_t;
    typedef logic [9:0]  sisl_addr_t;
endpackage : sisl_pkg
`default_nettype wire

// ==== design/sisl_flag_bank.sv ====
// eight sticky per-stage flags with clear-on-read unless the condition persists
`timescale 1ns/10ps
`default_nettype none
`include "sisl_map.svh"
module sisl_flag_bank (
    input  wire logic                     sys_clk,
    input  wire logic                     rst_b,
    input  wire sisl_pkg::sisl_stage_vec_t set_vec,
    input  wire sisl_pkg::sisl_stage_vec_t hold_vec,
    input  wire logic                     rd_clr,
    output var  sisl_pkg::sisl_stage_vec_t flag_q
);
    sisl_pkg::sisl_stage_vec_t flag_d;

    // ----------------------------------------
    // next state: set wins over the read clear
    // ----------------------------------------
    always_comb begin
        for (int i = `SISL_STAGE_LSB; i <= `SISL_STAGE_MSB; i++) begin
            flag_d[i] = set_vec[i] | (flag_q[i] & ~(rd_clr & ~hold_vec[i]));
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            flag_q <= `SISL_STS_RESET;
        end else begin
            flag_q <= flag_d;
        end
    end
endmodule : sisl_flag_bank
`default_nettype wire

// ==== design/sisl_irq_core.sv ====
// stage interrupt enable and status registers with the interrupt output
//
// How it works
// - bits 7:0 of the completion enable register let each stage's finished conversion raise the interrupt.
// - the low-limit status register holds one read-only bit per stage that sets on a low threshold exceedance.
// - the high-limit status register holds one read-only bit per stage that sets on a high threshold exceedance.
// - reading a limit status register clears each bit whose limit is no longer exceeded and keeps the rest.
// - per-stage low and high enable bits gate whether a latched limit drives the interrupt.
`timescale 1ns/10ps
`default_nettype none
`include "sisl_map.svh"
module sisl_irq_core (
    input  wire logic                     sys_clk,
    input  wire logic                     rst_b,
    input  wire sisl_pkg::sisl_addr_t     reg_addr,
    input  wire logic                     reg_wr,
    input  wire sisl_pkg::sisl_word_t     reg_wdata,
    input  wire logic                     reg_rd,
    output var  sisl_pkg::sisl_word_t     reg_rdata,
    input  wire sisl_pkg::sisl_stage_vec_t stage_done,
    input  wire sisl_pkg::sisl_stage_vec_t under_now,
    input  wire sisl_pkg::sisl_stage_vec_t over_now,
    output var  logic                     irq_b
);
    // ----------------------------------------
    // address decode
    // ----------------------------------------
    function automatic logic hit(input sisl_pkg::sisl_addr_t a, input sisl_pkg::sisl_addr_t t);
        hit = (a == t);
    endfunction : hit

    sisl_pkg::sisl_stage_vec_t den_q, den_d;
    sisl_pkg::sisl_stage_vec_t len_q, len_d;
    sisl_pkg::sisl_stage_vec_t hen_q, hen_d;
    logic                      tst_q, tst_d;
    sisl_pkg::sisl_word_t      rdata_d;
    logic                      irq_d;
    sisl_pkg::sisl_stage_vec_t done_q;
    sisl_pkg::sisl_stage_vec_t under_q;
    sisl_pkg::sisl_stage_vec_t over_q;
    logic                      rd_under, rd_over, rd_done;

    assign rd_under = reg_rd & hit(reg_addr, `SISL_ADDR_UNDER_STS);
    assign rd_over  = reg_rd & hit(reg_addr, `SISL_ADDR_OVER_STS);
    assign rd_done  = reg_rd & hit(reg_addr, `SISL_ADDR_DONE_STS);

    // ----------------------------------------
    // status flags
    // ----------------------------------------
    sisl_flag_bank u_done (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .set_vec (stage_done),
        .hold_vec(`SISL_NO_HOLD),
        .rd_clr  (rd_done),
        .flag_q  (done_q)
    );

    sisl_flag_bank u_under (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .set_vec (under_now),
        .hold_vec(under_now),
        .rd_clr  (rd_under),
        .flag_q  (under_q)
    );

    sisl_flag_bank u_over (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .set_vec (over_now),
        .hold_vec(over_now),
        .rd_clr  (rd_over),
        .flag_q  (over_q)
    );

    // ----------------------------------------
    // enable registers, read data, interrupt
    // ----------------------------------------
    always_comb begin
        den_d   = den_q;
        len_d   = len_q;
        hen_d   = hen_q;
        tst_d   = tst_q;
        rdata_d = `SISL_WORD_RESET;
        if (reg_wr && hit(reg_addr, `SISL_ADDR_DONE_EN)) begin
            den_d = reg_wdata[`SISL_STAGE_MSB:`SISL_STAGE_LSB];
            tst_d = reg_wdata[`SISL_TEST_BIT];
        end
        if (reg_wr && hit(reg_addr, `SISL_ADDR_UNDER_EN)) begin
            len_d = reg_wdata[`SISL_STAGE_MSB:`SISL_STAGE_LSB];
        end
        if (reg_wr && hit(reg_addr, `SISL_ADDR_OVER_EN)) begin
            hen_d = reg_wdata[`SISL_STAGE_MSB:`SISL_STAGE_LSB];
        end
        if (reg_rd) begin
            if (hit(reg_addr, `SISL_ADDR_DONE_EN)) begin
                rdata_d[`SISL_STAGE_MSB:`SISL_STAGE_LSB] = den_q;
                rdata_d[`SISL_TEST_BIT]                  = tst_q;
            end else if (hit(reg_addr, `SISL_ADDR_UNDER_EN)) begin
                rdata_d[`SISL_STAGE_MSB:`SISL_STAGE_LSB] = len_q;
            end else if (hit(reg_addr, `SISL_ADDR_OVER_EN)) begin
                rdata_d[`SISL_STAGE_MSB:`SISL_STAGE_LSB] = hen_q;
            end else if (hit(reg_addr, `SISL_ADDR_UNDER_STS)) begin
                rdata_d[`SISL_STAGE_MSB:`SISL_STAGE_LSB] = under_q;
            end else if (hit(reg_addr, `SISL_ADDR_OVER_STS)) begin
                rdata_d[`SISL_STAGE_MSB:`SISL_STAGE_LSB] = over_q;
            end else if (hit(reg_addr, `SISL_ADDR_DONE_STS)) begin
                rdata_d[`SISL_STAGE_MSB:`SISL_STAGE_LSB] = done_q;
            end
        end
        // any enabled pending source pulls the line low
        irq_d = ~|((done_q & den_q) | (under_q & len_q) | (over_q & hen_q));
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            den_q     <= `SISL_EN_RESET;
            len_q     <= `SISL_EN_RESET;
            hen_q     <= `SISL_EN_RESET;
            tst_q     <= `SISL_TEST_RESET;
            reg_rdata <= `SISL_WORD_RESET;
            irq_b     <= `SISL_IRQ_IDLE;
        end else begin
            den_q     <= den_d;
            len_q     <= len_d;
            hen_q     <= hen_d;
            tst_q     <= tst_d;
            reg_rdata <= rdata_d;
            irq_b     <= irq_d;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence s_done_hit;
        (|(stage_done & den_q)) && !reg_wr ##1 !reg_wr;
    endsequence

    sequence s_under_gone;
        rd_under && (under_now == `SISL_NO_HOLD);
    endsequence

    a_done_irq_raise: assert property (s_done_hit |=> !irq_b)
        else $error("enabled stage completion did not assert the interrupt");

    a_under_latch: assert property (|under_now |=> ((under_q & $past(under_now)) == $past(under_now)))
        else $error("low limit exceedance not latched");

    a_over_latch: assert property (|over_now |=> ((over_q & $past(over_now)) == $past(over_now)))
        else $error("high limit exceedance not latched");

    a_under_clear: assert property (s_under_gone |=> (under_q == `SISL_NO_HOLD))
        else $error("low status not cleared by read");

    a_over_keep: assert property (rd_over |=> ((over_q & $past(over_q & over_now)) == $past(over_q & over_now)))
        else $error("high status bit lost while limit persists");

    a_limit_gate: assert property ((len_q == `SISL_EN_RESET) && (hen_q == `SISL_EN_RESET) && (den_q == `SISL_EN_RESET) ##1 (len_q == `SISL_EN_RESET) && (hen_q == `SISL_EN_RESET) && (den_q == `SISL_EN_RESET) |-> irq_b)
        else $error("interrupt asserted with all sources disabled");

    a_irq_hold: assert property (((under_q & len_q) != `SISL_NO_HOLD) ##1 ((under_q & len_q) != `SISL_NO_HOLD) |-> !irq_b)
        else $error("interrupt released while an enabled source pends");

    sequence s_under_hit;
        (|(under_now & len_q)) && !reg_wr ##1 !reg_wr;
    endsequence

    sequence s_over_hit;
        (|(over_now & hen_q)) && !reg_wr ##1 !reg_wr;
    endsequence

    sequence s_none_pending;
        ((done_q & den_q) | (under_q & len_q) | (over_q & hen_q)) == `SISL_NO_HOLD;
    endsequence

    a_done_latch: assert property (|stage_done |=>
        ((done_q & $past(stage_done)) == $past(stage_done)))
        else $error("stage completion not latched");

    a_done_clear: assert property (rd_done && (stage_done == `SISL_NO_HOLD) |=>
        (done_q == `SISL_NO_HOLD))
        else $error("completion status not cleared by read");

    a_done_en_store: assert property (reg_wr && hit(reg_addr, `SISL_ADDR_DONE_EN) |=>
        (den_q == $past(reg_wdata[`SISL_STAGE_MSB:`SISL_STAGE_LSB])))
        else $error("completion enable write not stored");

    a_under_irq: assert property (s_under_hit |=> !irq_b)
        else $error("enabled low limit did not assert the interrupt");

    a_over_irq: assert property (s_over_hit |=> !irq_b)
        else $error("enabled high limit did not assert the interrupt");

    a_low_en_store: assert property (reg_wr && hit(reg_addr, `SISL_ADDR_UNDER_EN) |=>
        (len_q == $past(reg_wdata[`SISL_STAGE_MSB:`SISL_STAGE_LSB])))
        else $error("low enable write not stored");

    a_high_en_store: assert property (reg_wr && hit(reg_addr, `SISL_ADDR_OVER_EN) |=>
        (hen_q == $past(reg_wdata[`SISL_STAGE_MSB:`SISL_STAGE_LSB])))
        else $error("high enable write not stored");

    a_under_keep: assert property (rd_under |=>
        ((under_q & $past(under_q & under_now)) == $past(under_q & under_now)))
        else $error("low status bit lost while limit persists");

    a_over_clear: assert property (rd_over && (over_now == `SISL_NO_HOLD) |=>
        (over_q == `SISL_NO_HOLD))
        else $error("high status not cleared by read");

    a_under_read: assert property (rd_under |=>
        (reg_rdata == sisl_pkg::sisl_word_t'($past(under_q))))
        else $error("low status read data wrong");

    a_over_read: assert property (rd_over |=>
        (reg_rdata == sisl_pkg::sisl_word_t'($past(over_q))))
        else $error("high status read data wrong");

    a_rdata_idle: assert property (!reg_rd |=> (reg_rdata == `SISL_WORD_RESET))
        else $error("read data not zero without a read");

    a_irq_idle: assert property (s_none_pending |=> irq_b)
        else $error("interrupt asserted with nothing enabled pending");
endmodule : sisl_irq_core
`default_nettype wire

// ==== bench/sisl_host_model.sv ====
// host controller model issuing register accesses
`timescale 1ns/10ps
`default_nettype none
module sisl_host_model (
    input  wire logic                 sys_clk,
    input  wire sisl_pkg::sisl_word_t reg_rdata,
    output var  sisl_pkg::sisl_addr_t reg_addr,
    output var  logic                 reg_wr,
    output var  sisl_pkg::sisl_word_t reg_wdata,
    output var  logic                 reg_rd
);
    initial begin
        reg_addr = 10'h000;
        reg_wr = 1'b0;
        reg_wdata = 16'h0000;
        reg_rd = 1'b0;
    end
    task automatic wr(input sisl_pkg::sisl_addr_t a, input sisl_pkg::sisl_word_t d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= {8'h00, d[7:0]};
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask : wr
    task automatic rd(input sisl_pkg::sisl_addr_t a, output sisl_pkg::sisl_word_t d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd
endmodule : sisl_host_model
`default_nettype wire

// ==== bench/tb_top.sv ====
// self-checking bench for the stage interrupt block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic                      sys_clk = 1'b0;
    logic                      rst_b = 1'b0;
    sisl_pkg::sisl_addr_t      reg_addr;
    logic                      reg_wr;
    sisl_pkg::sisl_word_t      reg_wdata;
    logic                      reg_rd;
    sisl_pkg::sisl_word_t      reg_rdata;
    sisl_pkg::sisl_stage_vec_t stage_done = 8'h00;
    sisl_pkg::sisl_stage_vec_t under_now = 8'h00;
    sisl_pkg::sisl_stage_vec_t over_now = 8'h00;
    logic                      irq_b;
    int                        error_cnt = 0;
    int                        num_checks = 0;
    always #12.5 sys_clk = ~sys_clk;
    sisl_host_model sisl_host_model_i (.sys_clk(sys_clk), .reg_rdata(reg_rdata),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));
    sisl_irq_core sisl_irq_core_i (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .stage_done(stage_done), .under_now(under_now), .over_now(over_now), .irq_b(irq_b));
    task automatic chk(input string nm, input sisl_pkg::sisl_word_t s, input sisl_pkg::sisl_word_t e);
        num_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic rd_chk(input sisl_pkg::sisl_addr_t a, input sisl_pkg::sisl_word_t e);
        sisl_pkg::sisl_word_t v;
        sisl_host_model_i.rd(a, v);
        chk("reg_rdata", v, e);
    endtask : rd_chk
    task automatic wait_irq(input logic e);
        int n;
        n = 0;
        while (irq_b !== e && n < 4) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk("irq_b", {15'h0000, irq_b}, {15'h0000, e});
        if (irq_b !== e) test_done();
    endtask : wait_irq
    task automatic stay(input logic e);
        repeat (4) @(posedge sys_clk);
        #1;
        chk("irq_b", {15'h0000, irq_b}, {15'h0000, e});
    endtask : stay
    task automatic drive(input logic hi, input sisl_pkg::sisl_stage_vec_t v);
        @(posedge sys_clk);
        under_now <= hi ? 8'h00 : v;
        over_now  <= hi ? v : 8'h00;
    endtask : drive
    task automatic pulse(input sisl_pkg::sisl_stage_vec_t v);
        @(posedge sys_clk);
        stage_done <= v;
        @(posedge sys_clk);
        stage_done <= 8'h00;
        #1;
    endtask : pulse
    task automatic done_scn();
        sisl_host_model_i.wr(10'h007, 16'h0008);
        rd_chk(10'h007, 16'h0008);
        pulse(8'h01);
        stay(1'b1);
        rd_chk(10'h00a, 16'h0001);
        pulse(8'h08);
        wait_irq(1'b0);
        rd_chk(10'h00a, 16'h0008);
        wait_irq(1'b1);
    endtask : done_scn
    task automatic lim_scn(input logic hi, input sisl_pkg::sisl_addr_t a);
        drive(hi, 8'h05);
        drive(hi, 8'h04);
        rd_chk(a, 16'h0005);
        rd_chk(a, 16'h0004);
        drive(hi, 8'h00);
        rd_chk(a, 16'h0004);
        rd_chk(a, 16'h0000);
        stay(1'b1);
    endtask : lim_scn
    task automatic en_scn(input logic hi, input sisl_pkg::sisl_addr_t ea,
                          input sisl_pkg::sisl_addr_t sa);
        sisl_host_model_i.wr(ea, 16'h0004);
        drive(hi, 8'h04);
        wait_irq(1'b0);
        rd_chk(sa, 16'h0004);
        stay(1'b0);
        drive(hi, 8'h00);
        sisl_host_model_i.wr(ea, 16'h0000);
        stay(1'b1);
        rd_chk(sa, 16'h0004);
        rd_chk(sa, 16'h0000);
    endtask : en_scn
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done
    task automatic reset_scn();
        for (int a = 5; a < 11; a++) rd_chk(10'(a), 16'h0000);
        chk("irq_b", {15'h0000, irq_b}, 16'h0001);
        sisl_host_model_i.wr(10'h008, 16'h00ff);
        rd_chk(10'h008, 16'h0000);
        rd_chk(10'h3ff, 16'h0000);
    endtask : reset_scn
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        reset_scn();
        done_scn();
        lim_scn(1'b0, 10'h008);
        lim_scn(1'b1, 10'h009);
        en_scn(1'b0, 10'h005, 10'h008);
        en_scn(1'b1, 10'h006, 10'h009);
        test_done();
    end
endmodule : tb_top
`default_nettype wire
